// ===== logic/ptm_pkg.sv
// Purpose: shared constants for the four-instance periodic timer block
// Assumes: APB slave, 32-bit data, byte-wide registers in the low lane
// Notes: each register takes one aligned word
package ptm_pkg;

  localparam int unsigned NUM_TM = 4;
  localparam int unsigned NUM_WIDE = 2;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // address split: [11:8] area, [7:6] instance, [5:2] register word
  localparam int unsigned INST_HI = 7;
  localparam int unsigned INST_LO = 6;
  localparam int unsigned REG_HI = 5;
  localparam int unsigned REG_LO = 2;
  localparam int unsigned AREA_HI = 11;
  localparam int unsigned AREA_LO = 8;
  localparam logic [3:0] AREA_TM = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRESC = 12'h100;

  // per-instance register word indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RUN = 4'h1;
  localparam logic [3:0] REG_CNT_L = 4'h2;
  localparam logic [3:0] REG_CNT_H = 4'h3;
  localparam logic [3:0] REG_CMPA_L = 4'h4;
  localparam logic [3:0] REG_CMPA_H = 4'h5;
  localparam logic [3:0] REG_PER_L = 4'h6;
  localparam logic [3:0] REG_PER_H = 4'h7;
  localparam logic [3:0] REG_FLAG = 4'h8;

  // timer_control_one fields
  localparam int unsigned CTRL_MODE_HI = 7;
  localparam int unsigned CTRL_MODE_LO = 6;
  localparam int unsigned CTRL_PIN_HI = 5;
  localparam int unsigned CTRL_PIN_LO = 4;
  localparam int unsigned CTRL_OC = 3;
  localparam int unsigned CTRL_POL = 2;
  localparam int unsigned CTRL_CCLR = 0;
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned FLAG_A = 0;
  localparam int unsigned FLAG_P = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] WIDE_MAX = 16'hFFFF;
  localparam logic [15:0] NARROW_MAX = 16'h03FF;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } ptm_mode_t;

  // compare-mode pin actions
  localparam logic [1:0] PA_NONE = 2'b00;
  localparam logic [1:0] PA_LOW = 2'b01;
  localparam logic [1:0] PA_HIGH = 2'b10;
  localparam logic [1:0] PA_TOGGLE = 2'b11;
  // pwm-mode pin actions
  localparam logic [1:0] PA_INACT = 2'b00;
  localparam logic [1:0] PA_ACT = 2'b01;
  localparam logic [1:0] PA_PWM = 2'b10;
  localparam logic [1:0] PA_PULSE = 2'b11;

endpackage

// ===== logic/ptm_top.sv
// Purpose: four periodic timers with compare, timer and pwm modes, APB regs
// Assumes: one clock, inputs synchronous, zero-wait APB with one setup cycle
// Notes: instances 0,1 are 16 bits wide, instances 2,3 are 10 bits wide
// Notes on behaviour
// - mode 00 is compare match output
// - clear-select low: clear on period or overflow
// - clear-select high: clear on compare-A or overflow
// - compare-A zero: run to maximum, no flag
// - compare mode pin moves only on A flag
// - pin action: high, low, toggle, or none
// - run rising edge loads initial pin level
// - mode 11 like compare, pin not driven
// - mode 10 is pwm, clear-select ignored
// - pwm: period sets frequency, compare-A duty
// - pwm raises A and period flags
// - pwm: level ctrl, pin action, invert bit
// - period zero gives full-range period count
// - counter readable bytes, 16 bits wide
// - narrow counter upper bits read zero
// - compare and period rw, reset zero, masked
// - compare pin codes: none, low, high, toggle
// - pwm codes: inactive, active, pwm; pulse code gives the inactive level
`timescale 1ns/10ps
module ptm_top
  import ptm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [NUM_TM-1:0] pin_out,
  output logic [NUM_TM-1:0] pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup;
  logic wr_en;
  logic in_tm;
  logic [1:0] inst_sel;
  logic [3:0] reg_sel;
  logic [7:0] wbyte;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rdata;
  logic hit;

  assign setup = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pready_r & pwrite_in;
  assign in_tm = (paddr_in[AREA_HI:AREA_LO] == AREA_TM) &&
                 (paddr_in[1:0] == 2'b00);
  assign inst_sel = paddr_in[INST_HI:INST_LO];
  assign reg_sel = paddr_in[REG_HI:REG_LO];
  assign wbyte = pwdata_in[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // timer clock divider

  logic [7:0] presc_r;
  logic [7:0] div_cnt_r;
  logic tick;

  assign tick = (div_cnt_r == presc_r);

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= PRESC_RST;
    end else if (wr_en && paddr_in == ADDR_PRESC) begin
      presc_r <= wbyte;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= PRESC_RST;
    end else if (tick) begin
      div_cnt_r <= PRESC_RST;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer instances

  logic [7:0] ctrl_r [NUM_TM];
  logic run_r [NUM_TM];
  logic [15:0] cnt_r [NUM_TM];
  logic [15:0] cmpa_r [NUM_TM];
  logic [15:0] per_r [NUM_TM];
  logic [1:0] flag_r [NUM_TM];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TM; gi++) begin : g_tm
      localparam logic [15:0] MAXV = (gi < NUM_WIDE) ? WIDE_MAX : NARROW_MAX;
      ptm_mode_t mode;
      logic [1:0] pact;
      logic oc;
      logic pol;
      logic cclr;
      logic wsel;
      logic step;
      logic [15:0] cnt_inc;
      logic ovf;
      logic a_hit;
      logic p_hit;
      logic use_a_clr;
      logic clr;
      logic clr_a_req;
      logic clr_p_req;
      logic set_a;
      logic set_p;
      logic run_d_r;
      logic run_rise;
      logic pin_r;
      logic pwm_act;
      logic pwm_lvl;
      logic out_nxt;
      logic oe_nxt;
      logic out_r;
      logic oe_r;

      assign mode = ptm_mode_t'(ctrl_r[gi][CTRL_MODE_HI:CTRL_MODE_LO]);
      assign pact = ctrl_r[gi][CTRL_PIN_HI:CTRL_PIN_LO];
      assign oc = ctrl_r[gi][CTRL_OC];
      assign pol = ctrl_r[gi][CTRL_POL];
      assign cclr = ctrl_r[gi][CTRL_CCLR];
      assign wsel = wr_en && in_tm && (inst_sel == 2'(gi));

      // counting core
      assign step = run_r[gi] & tick;
      assign cnt_inc = (cnt_r[gi] + CNT_ONE) & MAXV;
      assign ovf = (cnt_r[gi] == MAXV);
      // a zero compare-A never matches
      assign a_hit = step && (cmpa_r[gi] != VAL_RST) &&
                     (cnt_inc == cmpa_r[gi]);
      // period zero means the full range
      always_comb begin
        if (per_r[gi] != VAL_RST) begin
          p_hit = step && (cnt_inc == per_r[gi]);
        end else begin
          p_hit = step && ovf;
        end
      end
      // clear-select counts only in compare and timer modes
      assign use_a_clr = cclr &&
                         (mode == MODE_CMP || mode == MODE_TMR);
      always_comb begin
        if (use_a_clr) begin
          clr = a_hit | (step & ovf);
        end else begin
          clr = p_hit | (step & ovf);
        end
      end
      assign set_a = a_hit;
      assign set_p = p_hit & ~use_a_clr;

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r[gi] <= VAL_RST;
        end else if (step) begin
          cnt_r[gi] <= clr ? VAL_RST : cnt_inc;
        end
      end

      // registers written by software
      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_r[gi] <= CTRL_RST;
        end else if (wsel && reg_sel == REG_CTRL) begin
          ctrl_r[gi] <= wbyte;
        end
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          run_r[gi] <= 1'b0;
        end else if (wsel && reg_sel == REG_RUN) begin
          run_r[gi] <= wbyte[RUN_BIT];
        end
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          cmpa_r[gi] <= VAL_RST;
          per_r[gi] <= VAL_RST;
        end else if (wsel) begin
          unique case (reg_sel)
            REG_CMPA_L: cmpa_r[gi] <= {cmpa_r[gi][15:8], wbyte} & MAXV;
            REG_CMPA_H: cmpa_r[gi] <= {wbyte, cmpa_r[gi][7:0]} & MAXV;
            REG_PER_L: per_r[gi] <= {per_r[gi][15:8], wbyte} & MAXV;
            REG_PER_H: per_r[gi] <= {wbyte, per_r[gi][7:0]} & MAXV;
            default: begin
            end
          endcase
        end
      end

      // sticky flags, write one to clear, a new event wins
      assign clr_a_req = wsel && (reg_sel == REG_FLAG) && wbyte[FLAG_A];
      assign clr_p_req = wsel && (reg_sel == REG_FLAG) && wbyte[FLAG_P];

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          flag_r[gi] <= 2'b00;
        end else begin
          if (set_a) begin
            flag_r[gi][FLAG_A] <= 1'b1;
          end else if (clr_a_req) begin
            flag_r[gi][FLAG_A] <= 1'b0;
          end
          if (set_p) begin
            flag_r[gi][FLAG_P] <= 1'b1;
          end else if (clr_p_req) begin
            flag_r[gi][FLAG_P] <= 1'b0;
          end
        end
      end

      // compare-mode pin state
      assign run_rise = run_r[gi] & ~run_d_r;

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          run_d_r <= 1'b0;
        end else begin
          run_d_r <= run_r[gi];
        end
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          pin_r <= 1'b0;
        end else if (run_rise) begin
          pin_r <= oc;
        end else if (set_a && mode == MODE_CMP) begin
          unique case (pact)
            PA_NONE: pin_r <= pin_r;
            PA_LOW: pin_r <= 1'b0;
            PA_HIGH: pin_r <= 1'b1;
            PA_TOGGLE: pin_r <= ~pin_r;
          endcase
        end
      end

      // pwm level: active while count below duty
      assign pwm_act = (cnt_r[gi] < cmpa_r[gi]);

      always_comb begin
        unique case (pact)
          PA_INACT: pwm_lvl = ~oc;
          PA_ACT: pwm_lvl = oc;
          PA_PWM: pwm_lvl = pwm_act ? oc : ~oc;
          PA_PULSE: pwm_lvl = ~oc;
        endcase
      end

      always_comb begin
        unique case (mode)
          MODE_CMP: begin
            out_nxt = pin_r ^ pol;
            oe_nxt = 1'b1;
          end
          MODE_PWM: begin
            out_nxt = pwm_lvl ^ pol;
            oe_nxt = 1'b1;
          end
          MODE_CAP: begin
            out_nxt = 1'b0;
            oe_nxt = 1'b0;
          end
          MODE_TMR: begin
            out_nxt = 1'b0;
            oe_nxt = 1'b0;
          end
        endcase
      end

      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          out_r <= 1'b0;
          oe_r <= 1'b0;
        end else begin
          out_r <= out_nxt;
          oe_r <= oe_nxt;
        end
      end

      assign pin_out[gi] = out_r;
      assign pin_oe_out[gi] = oe_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb response

  always_comb begin
    rdata = '0;
    hit = 1'b1;
    if (paddr_in == ADDR_PRESC) begin
      rdata[7:0] = presc_r;
    end else if (in_tm) begin
      unique case (reg_sel)
        REG_CTRL: rdata[7:0] = ctrl_r[inst_sel];
        REG_RUN: rdata[RUN_BIT] = run_r[inst_sel];
        REG_CNT_L: rdata[7:0] = cnt_r[inst_sel][7:0];
        REG_CNT_H: rdata[7:0] = cnt_r[inst_sel][15:8];
        REG_CMPA_L: rdata[7:0] = cmpa_r[inst_sel][7:0];
        REG_CMPA_H: rdata[7:0] = cmpa_r[inst_sel][15:8];
        REG_PER_L: rdata[7:0] = per_r[inst_sel][7:0];
        REG_PER_H: rdata[7:0] = per_r[inst_sel][15:8];
        REG_FLAG: rdata[1:0] = flag_r[inst_sel];
        default: hit = 1'b0;
      endcase
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup & ~hit;
    end
  end

  // read data holds until the next read setup
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (setup && !pwrite_in) begin
      prdata_r <= rdata;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;

endmodule // ptm_top

// ===== tb/ptm_top_sva.sv
// Purpose: port-level checks for ptm_top
// Assumes: apb writes to instance 0 are seen at the ports
// Notes: shadows instance 0 control and run bits
`timescale 1ns/10ps
module ptm_top_chk
  import ptm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [NUM_TM-1:0] pin_out,
  input wire logic [NUM_TM-1:0] pin_oe_out
);
  logic [7:0] c0_r;
  logic run0_r;
  logic [1:0] up_r;
  logic wr, rd, ok;
  assign wr = psel_in & penable_in & pready_out & pwrite_in;
  assign rd = psel_in & penable_in & pready_out & !pwrite_in;
  // settled some cycles after reset release
  assign ok = (up_r == 2'h3);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  //////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      c0_r <= 8'h00;
      run0_r <= 1'b0;
      up_r <= 2'h0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      if (wr && paddr_in == 12'h000) c0_r <= pwdata_in[7:0];
      if (wr && paddr_in == 12'h004) run0_r <= pwdata_in[0];
    end
  end
  //////////////////////////////////////////////////////////////
  cmp_oe_on_a: assert property (ok && $stable(c0_r) &&
    c0_r[7:6] == 2'b00 |-> pin_oe_out[0]) else $error("oe low cmp");
  pwm_oe_on_a: assert property (ok && $stable(c0_r) &&
    c0_r[7:6] == 2'b10 |-> pin_oe_out[0]) else $error("oe low pwm");
  tmr_oe_off_a: assert property (ok && $stable(c0_r) &&
    c0_r[7:6] == 2'b11 |-> !pin_oe_out[0]) else $error("oe high tmr");
  run_init_a: assert property (ok && $rose(run0_r) &&
    c0_r[7:6] == 2'b00 |-> ##[1:3] pin_out[0] == (c0_r[3] ^ c0_r[2]))
    else $error("init level");
  pwm_force_a: assert property (ok && run0_r && $past(run0_r, 3) &&
    c0_r[7:4] == 4'b1001 && $past(c0_r, 3) == c0_r
    |-> pin_out[0] == (c0_r[3] ^ c0_r[2])) else $error("forced level");
  cnt_hi_mask_a: assert property (rd && paddr_in[7] &&
    paddr_in[5:2] == REG_CNT_H |-> prdata_out[31:2] == 30'h0)
    else $error("count high bits");
  val_hi_mask_a: assert property (rd && paddr_in[7] &&
    (paddr_in[5:2] == REG_CMPA_H || paddr_in[5:2] == REG_PER_H)
    |-> prdata_out[31:2] == 30'h0) else $error("value high bits");
  byte_read_a: assert property (rd |->
    prdata_out[31:8] == 24'h0) else $error("read above byte");
endmodule // ptm_top_chk

bind ptm_top ptm_top_chk u_chk (.core_clk_in, .resetn_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .pready_out, .pslverr_out, .pin_out, .pin_oe_out);

// ===== tb/ptm_top_test.sv
// Purpose: self-checking bench for ptm_top
// Assumes: zero-wait apb; a reset zeroes every counter
// Notes: reads checked by a queue monitor
`timescale 1ns/10ps
module ptm_top_test
  import ptm_pkg::*;
;
  logic core_clk_in, resetn_in, psel_in, penable_in, pwrite_in;
  logic [ADDR_W-1:0] paddr_in;
  logic [DATA_W-1:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out;
  logic [NUM_TM-1:0] pin_out, pin_oe_out;
  logic [32:0] exp_q[$];
  logic [7:0] d, c;
  logic [1:0] e, i;
  logic [15:0] hi;
  logic oc;
  logic [7:0] ct[6] = '{8'hA9, 8'hAD, 8'hA1, 8'h99, 8'h89, 8'hA8};
  logic [15:0] ex[6] = '{16'h001E, 16'h0046, 16'h0046, 16'h0064,
    16'h0000, 16'h0200};
  int n_mismatch, checks, cyc;
  ptm_top dut (.core_clk_in, .resetn_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .pin_out, .pin_oe_out);
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  //////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (checks > 0 && n_mismatch == 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
      cmp({pslverr_out, prdata_out}, exp_q.pop_front());
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input int n, input int r,
      input logic [7:0] dv, input logic [32:0] ev);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= 12'(n * 64 + r * 4);
    pwdata_in <= {24'h0, dv};
    if (!w) exp_q.push_back(ev);
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1) @(posedge core_clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input int n, input int r, input logic [7:0] dv);
    apb(1'b1, n, r, dv, 33'h0);
  endtask
  task automatic rd(input int n, input int r, input logic [7:0] ev);
    apb(1'b0, n, r, 8'h00, {25'h0, ev});
  endtask
  task automatic rst();
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
  endtask
  // reset stops the timer and zeroes the counter before reconfiguring
  task automatic setup(input int n, input logic [7:0] cv,
      input logic [7:0] al, input logic [7:0] ah, input logic [7:0] p);
    rst();
    wr(n, REG_CTRL, cv);
    wr(n, REG_CMPA_L, al);
    wr(n, REG_CMPA_H, ah);
    wr(n, REG_PER_L, p);
    wr(n, REG_RUN, 8'h01);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = '0;
    pwdata_in = '0;
    void'($urandom(23113));
    rst();
    for (int n = 0; n < 4; n++) begin
      for (int r = 0; r < 9; r++) rd(n, r, 8'h00);
      for (int r = 4; r < 8; r++) begin
        d = 8'($urandom);
        wr(n, r, d);
        rd(n, r, (n > 1 && r[0]) ? d & 8'h03 : d);
      end
    end
    cmp({25'h0, pin_oe_out, pin_out}, {25'h0, 4'hF, 4'h0});
    wr(2, REG_CNT_H, 8'hFF);
    rd(2, REG_CNT_H, 8'h00);
    apb(1'b0, 3, 15, 8'h00, {1'b1, 32'h0});
    setup(0, 8'h00, 8'h03, 8'h00, 8'h05);
    repeat (20) @(posedge core_clk_in);
    rd(0, REG_FLAG, 8'h03);
    setup(0, 8'h01, 8'h04, 8'h00, 8'h02);
    repeat (20) @(posedge core_clk_in);
    rd(0, REG_FLAG, 8'h01);
    setup(0, 8'hC0, 8'h03, 8'h00, 8'h05);
    repeat (20) @(posedge core_clk_in);
    rd(0, REG_FLAG, 8'h03);
    setup(2, 8'h00, 8'h00, 8'h00, 8'h00);
    repeat (500) @(posedge core_clk_in);
    rd(2, REG_FLAG, 8'h00);
    repeat (600) @(posedge core_clk_in);
    rd(2, REG_FLAG, 8'h02);
    for (int k = 0; k < 6; k++) begin
      oc = 1'($urandom);
      c = {4'(k), oc, 3'b001};
      i = {1'b1, oc};
      e = (k == 1) ? 2'b10 : (k == 2) ? 2'b11 : (k == 3) ? {1'b1, !oc} : i;
      if (k == 4) c = {4'b0011, oc, 3'b000};
      if (k == 5) begin
        c = 8'hC0;
        i = 2'b00;
        e = 2'b00;
      end
      setup(0, c, 8'hC8, 8'h00, (k == 4) ? 8'h32 : 8'h00);
      repeat (4) @(posedge core_clk_in);
      cmp({31'h0, pin_oe_out[0], pin_out[0] & pin_oe_out[0]},
        {31'h0, i});
      repeat (246) @(posedge core_clk_in);
      cmp({31'h0, pin_oe_out[0], pin_out[0] & pin_oe_out[0]},
        {31'h0, e});
    end
    for (int k = 0; k < 6; k++) begin
      if (k < 5) setup(0, ct[k], 8'h03, 8'h00, 8'h0A);
      else setup(2, ct[k], 8'h00, 8'h02, 8'h00);
      repeat (20) @(posedge core_clk_in);
      hi = 16'h0;
      repeat ((k < 5) ? 100 : 1024) begin
        @(negedge core_clk_in);
        hi = hi + {15'h0, pin_out[(k < 5) ? 0 : 2]};
      end
      cmp({17'h0, hi}, {17'h0, ex[k]});
    end
    rd(2, REG_FLAG, 8'h03);
    repeat (2) @(posedge core_clk_in);
    end_sim();
  end
endmodule // ptm_top_test
